// *** shared/lsd_pkg.sv ***
package lsd_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int CH_N = 16;
	localparam int GAIN_W = 6;
	localparam int GAIN_LSB = 0;
	localparam int CNT_W = 5;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int EVT_W = 4;

	// ----------------------------------------
	// Pulse counts seen while the strobe is high
	// ----------------------------------------
	localparam logic [CNT_W-1:0] CMD_FAULT_RD = 5'h02;
	localparam logic [CNT_W-1:0] CMD_TEMP_RD = 5'h03;
	localparam logic [CNT_W-1:0] CMD_FORCE = 5'h07;
	localparam logic [CNT_W-1:0] CMD_CFG_WR = 5'h0B;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1F;

	// ----------------------------------------
	// Register offsets and reset values
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CLEAR = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ENABLE = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_FAULT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_LATCH = 8'h14;
	localparam logic [DATA_W-1:0] CFG_RST = 16'h0000;
	localparam logic [DATA_W-1:0] FAULT_RST = 16'hFFFF;
	localparam logic [EVT_W-1:0] IRQ_EN_RST = 4'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int FORCE_TIME_NS = 500;
	localparam int FORCE_CYC_RAW = (FORCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FORCE_CYC = (FORCE_CYC_RAW < 1) ? 1 : FORCE_CYC_RAW;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FORCE = 2'b01,
		ST_SAMPLE = 2'b11
	} lsd_state_e;

	typedef struct packed {
		logic temp_warn;
		logic fault_seen;
		logic force_done;
		logic cfg_written;
	} lsd_evt_s;
endpackage

// *** testbench/lsd_ctrl_model.sv ***
`timescale 1ns/10ps
module lsd_ctrl_model (
	output logic link_clk_out,
	output logic serial_data_out,
	output logic strobe_out,
	input wire logic chain_in
);
	// ----------------------------------------
	// Display controller
	// ----------------------------------------
	// Link clock rests low between frames
	initial begin
		link_clk_out = 1'b0;
		serial_data_out = 1'b0;
		strobe_out = 1'b0;
	end
	// 800 ns link period; odd start offset keeps edges off the system clock
	task automatic frame(input logic [15:0] din, input logic [4:0] k, output logic [15:0] dout);
		#13;
		for (int i = 15; i >= 0; i--) begin
			serial_data_out = din[i];
			#400;
			dout[i] = chain_in;
			link_clk_out = 1'b1;
			#400;
			link_clk_out = 1'b0;
		end
		serial_data_out = ~din[0]; // Released line shows no stale bit
		strobe_out = 1'b1;
		#400;
		repeat (k) begin
			link_clk_out = 1'b1;
			#400;
			link_clk_out = 1'b0;
			#400;
		end
		strobe_out = 1'b0;
		#1600;
	endtask
endmodule

// *** testbench/lsd_props.sv ***
`timescale 1ns/10ps
module lsd_props import lsd_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic out_en_n_in,
	input wire logic link_clk_in,
	input wire logic latch_strobe_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic serial_out_out,
	input wire logic [CH_N-1:0] sink_channels_out,
	input wire logic test_current_out,
	input wire logic [GAIN_W-1:0] gain_code_out,
	input wire logic [DATA_W-1:0] reg_rdata_out,
	input wire logic irq_out
);
	// ----------------------------------------
	// Port relations
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// Five quiet cycles cover the synchroniser and the output register
	a_blank_when_off: assert property (out_en_n_in[*5] ##0 !test_current_out |-> sink_channels_out == '0)
		else $error("channels lit while blanked");
	a_test_all_lit: assert property (test_current_out |-> sink_channels_out == 16'hFFFF)
		else $error("channel dark during forced check");
	a_test_length: assert property ($rose(test_current_out) |-> test_current_out[*5] ##[1:3] !test_current_out)
		else $error("forced check length wrong");
	a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
		else $error("read data outside its cycle");
	a_unmapped_zero: assert property ($past(reg_rd_in) && $past(reg_addr_in) > REG_LATCH |-> reg_rdata_out == '0)
		else $error("unmapped read not zero");
	a_gain_matches_cfg: assert property ($past(reg_rd_in) && $past(reg_addr_in) == REG_CONFIG
		|-> reg_rdata_out[GAIN_W-1:0] == $past(gain_code_out))
		else $error("gain differs from config");
	a_irq_off_masked: assert property (reg_wr_in && reg_addr_in == REG_ENABLE && reg_wdata_in[3:0] == 4'h0
		|-> ##[2:3] !irq_out)
		else $error("irq high with all masked");
	// A quiet link leaves nothing to move the chain bit
	a_sout_quiet: assert property ((!link_clk_in && !latch_strobe_in)[*8] |=> $stable(serial_out_out))
		else $error("serial out moved on quiet link");
	c_forced: cover property ($rose(test_current_out));
	c_irq: cover property ($rose(irq_out));
	c_sout: cover property ($rose(serial_out_out));
endmodule

bind lsd_top lsd_props u_props (.clk_in, .sys_rst_in, .out_en_n_in, .link_clk_in, .latch_strobe_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .serial_out_out, .sink_channels_out, .test_current_out, .gain_code_out,
	.reg_rdata_out, .irq_out);

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb import lsd_pkg::*; ;
	logic clk_in, sys_rst_in, out_en_n_in, over_temp_in, reg_wr_in, reg_rd_in;
	logic link_clk, sdata, strobe, serial_out_out, test_current_out, irq_out;
	logic [CH_N-1:0] chan_open_in, chan_short_in, sink_channels_out, lit_seen;
	logic [ADDR_W-1:0] reg_addr_in;
	logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, d;
	logic [GAIN_W-1:0] gain_code_out;
	int n_mismatch = 0;
	int cmp_count = 0;
	int tc_cycles = 0;
	// ----------------------------------------
	// Harness
	// ----------------------------------------
	lsd_top u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk), .serial_in_in(sdata),
		.latch_strobe_in(strobe), .out_en_n_in(out_en_n_in), .chan_open_in(chan_open_in),
		.chan_short_in(chan_short_in), .over_temp_in(over_temp_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .serial_out_out(serial_out_out),
		.sink_channels_out(sink_channels_out), .test_current_out(test_current_out), .gain_code_out(gain_code_out),
		.reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
	lsd_ctrl_model u_ctrl (.link_clk_out(link_clk), .serial_data_out(sdata), .strobe_out(strobe),
		.chain_in(serial_out_out));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// Forced window is short, so record it as it happens, between edges
	always @(negedge clk_in) begin
		if (test_current_out === 1'b1) begin
			tc_cycles++;
			lit_seen = sink_channels_out;
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Ends between edges so outputs have settled
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		@(negedge clk_in);
		v = reg_rdata_out;
	endtask
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_display();
		@(posedge clk_in);
		out_en_n_in <= 1'b0;
		chan_short_in <= 16'h0002;
		u_ctrl.frame(16'hA5C3, 5'h00, d);
		wait_cyc(4);
		chk("sink", 16'hA5C3, sink_channels_out);
		rd(REG_LATCH, d);
		chk("latch reg", 16'hA5C3, d);
		rd(REG_FAULT, d);
		chk("display fault", 16'hFFFD, d);
		u_ctrl.frame(16'hA5C3, CMD_CFG_WR, d);
		chk("chain out", 16'hA5C3, d);
		@(posedge clk_in);
		out_en_n_in <= 1'b1;
		chan_short_in <= '0;
		wait_cyc(5);
		chk("blank", 16'h0000, sink_channels_out);
	endtask
	task automatic t_config();
		wr(REG_CLEAR, 16'h000F);
		u_ctrl.frame(16'h002A, CMD_CFG_WR, d);
		wait_cyc(2);
		chk("gain", 16'h002A, {10'h000, gain_code_out});
		wr(REG_CONFIG, 16'hFFFF);
		rd(REG_CONFIG, d);
		chk("config", 16'h002A, d);
		rd(8'h3C, d);
		chk("unmapped", 16'h0000, d);
		wr(REG_ENABLE, 16'h0001);
		rd(REG_ENABLE, d);
		chk("enable reg", 16'h0001, d);
		wait_cyc(3);
		chk("irq on", 16'h0001, {15'h0, irq_out});
		wr(REG_CLEAR, 16'h0001);
		wait_cyc(3);
		chk("irq cleared", 16'h0000, {15'h0, irq_out});
		wr(REG_ENABLE, 16'h0000);
	endtask
	task automatic t_force();
		@(posedge clk_in);
		chan_open_in <= 16'h0008;
		over_temp_in <= 1'b1;
		out_en_n_in <= 1'b0;
		u_ctrl.frame(16'h0000, CMD_FORCE, d);
		chk("forced lit", 16'hFFFF, lit_seen);
		chk("forced cycles", 16'(FORCE_CYC + 1), 16'(tc_cycles));
		rd(REG_FAULT, d);
		chk("forced fault", 16'hFFF7, d);
		u_ctrl.frame(16'h0000, CMD_FAULT_RD, d);
		u_ctrl.frame(16'h0000, 5'h01, d);
		chk("fault chain", 16'hFFF7, d);
		u_ctrl.frame(16'h0000, CMD_TEMP_RD, d);
		u_ctrl.frame(16'h0000, 5'h01, d);
		chk("temp chain", 16'h0001, d);
		rd(REG_STATUS, d);
		chk("status", 16'h000E, d);
	endtask
	initial begin
		#2000000;
		n_mismatch++;
		wrap_up();
	end
	initial begin
		sys_rst_in = 1'b1;
		out_en_n_in = 1'b1;
		over_temp_in = 1'b0;
		chan_open_in = '0;
		chan_short_in = '0;
		reg_addr_in = '0;
		reg_wdata_in = '0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		t_display();
		t_config();
		t_force();
		wrap_up();
	end
endmodule

// *** verilog/lsd_cycle_timer.sv ***
`timescale 1ns/10ps
// Loadable down-counter; done pulses in the last busy cycle, while the count is one
module lsd_cycle_timer import lsd_pkg::*; #(
	parameter int CYC = FORCE_CYC
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic start_in,
	output logic busy_out,
	output logic done_out
);
	localparam int TW = $clog2(CYC + 1);
	localparam logic [TW-1:0] LOAD = TW'(CYC);

	logic [TW-1:0] cnt_ff;
	logic [TW-1:0] nxt_cnt;

	if (CYC < 1) begin : g_bad_cyc
		$error("lsd_cycle_timer: CYC must be at least 1");
	end

	// Restart wins over a running count
	always_comb begin
		nxt_cnt = cnt_ff;
		if (start_in) begin
			nxt_cnt = LOAD;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - TW'(1);
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign busy_out = (cnt_ff != '0);
	assign done_out = (cnt_ff == TW'(1));
endmodule

// *** verilog/lsd_sync_edge.sv ***
`timescale 1ns/10ps
// Two-flop synchroniser with a third stage for edge finding
module lsd_sync_edge import lsd_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_out,
	output logic [W-1:0] rise_out,
	output logic [W-1:0] fall_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] prev_ff;

	if (W < 1) begin : g_bad_width
		$error("lsd_sync_edge: W must be at least 1");
	end

	// Only sync_ff reads meta_ff; edges come from the settled stages
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign level_out = sync_ff;
	assign rise_out = sync_ff & ~prev_ff;
	assign fall_out = ~sync_ff & prev_ff;
endmodule

// *** verilog/lsd_top.sv ***
`timescale 1ns/10ps
// Function
// - Sixteen-bit shift register and separate sixteen-bit output latch feed the channels.
// - Each rising serial clock edge with the strobe low shifts in the serial input bit.
// - Bit leaving the shift register end drives the serial output for cascading.
// - Clock pulses counted while the strobe is high select a command.
// - Configuration command copies shift register into configuration register on strobe fall.
// - Six-bit gain code selects one of 64 steps, 12.5% to 200%.
// - Output enable low lets channels sink; high blanks every channel outside forced detection.
// - Forced detection lights all channels briefly at test current, checks every one.
// - Lit channels are checked for open and short faults during display.
// - Open and short merge into one zero-coded bit per channel, shifted out.
// - Over-temperature warning flag follows the synchronised input each cycle and can be read back.
module lsd_top import lsd_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic link_clk_in,
	input wire logic serial_in_in,
	input wire logic latch_strobe_in,
	input wire logic out_en_n_in,
	input wire logic [CH_N-1:0] chan_open_in,
	input wire logic [CH_N-1:0] chan_short_in,
	input wire logic over_temp_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic serial_out_out,
	output logic [CH_N-1:0] sink_channels_out,
	output logic test_current_out,
	output logic [GAIN_W-1:0] gain_code_out,
	output logic [DATA_W-1:0] reg_rdata_out,
	output logic irq_out
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Clock, data and strobe share one synchroniser so they stay aligned
	localparam int LW = 3;
	logic [LW-1:0] link_lvl;
	logic [LW-1:0] link_rise;
	logic [LW-1:0] link_fall;
	logic serial_bit;
	logic strobe_lvl;
	logic clk_rise;
	logic strobe_fall;

	lsd_sync_edge #(.W(LW)) u_link_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({latch_strobe_in, serial_in_in, link_clk_in}),
		.level_out(link_lvl),
		.rise_out(link_rise),
		.fall_out(link_fall)
	);

	assign clk_rise = link_rise[0];
	assign serial_bit = link_lvl[1];
	assign strobe_lvl = link_lvl[2];
	assign strobe_fall = link_fall[2];

	// Detector and enable inputs come from analogue or far logic
	localparam int DW = 2 * CH_N + 2;
	logic [DW-1:0] det_lvl;
	logic [CH_N-1:0] open_s;
	logic [CH_N-1:0] short_s;
	logic temp_s;
	logic oe_n_s;

	lsd_sync_edge #(.W(DW)) u_det_sync (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.async_in({out_en_n_in, over_temp_in, chan_short_in, chan_open_in}),
		.level_out(det_lvl),
		.rise_out(),
		.fall_out()
	);

	assign open_s = det_lvl[CH_N-1:0];
	assign short_s = det_lvl[2*CH_N-1:CH_N];
	assign temp_s = det_lvl[2*CH_N];
	assign oe_n_s = det_lvl[2*CH_N+1];

	// ----------------------------------------
	// Forced detection timing
	// ----------------------------------------
	logic force_start;
	logic force_busy;
	logic force_done;

	lsd_cycle_timer #(.CYC(FORCE_CYC)) u_force_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(force_start),
		.busy_out(force_busy),
		.done_out(force_done)
	);

	// ----------------------------------------
	// Serial path and command decode
	// ----------------------------------------
	logic [CH_N-1:0] shift_ff;
	logic [CH_N-1:0] nxt_shift;
	logic [CH_N-1:0] latch_ff;
	logic [CH_N-1:0] nxt_latch;
	logic [DATA_W-1:0] cfg_ff;
	logic [DATA_W-1:0] nxt_cfg;
	logic [CNT_W-1:0] pulse_cnt_ff;
	logic [CNT_W-1:0] nxt_pulse_cnt;
	logic serial_out_ff;
	logic nxt_serial_out;
	logic cfg_written;
	logic [CH_N-1:0] fault_ff;
	logic temp_flag_ff;

	// Pulses under the strobe only count; shifting stops so that
	// the word to be latched is not disturbed by the command
	always_comb begin
		nxt_shift = shift_ff;
		nxt_latch = latch_ff;
		nxt_cfg = cfg_ff;
		nxt_pulse_cnt = pulse_cnt_ff;
		cfg_written = 1'b0;
		force_start = 1'b0;
		if (strobe_fall) begin
			nxt_pulse_cnt = '0;
			unique case (pulse_cnt_ff)
				CMD_CFG_WR: begin
					nxt_cfg = shift_ff;
					cfg_written = 1'b1;
				end
				CMD_FORCE: begin
					force_start = 1'b1;
				end
				CMD_FAULT_RD: begin
					nxt_shift = fault_ff;
				end
				CMD_TEMP_RD: begin
					nxt_shift = {{(CH_N-1){1'b0}}, temp_flag_ff};
				end
				default: begin
					nxt_latch = shift_ff;
				end
			endcase
		end else if (clk_rise && strobe_lvl) begin
			if (pulse_cnt_ff != CNT_MAX) begin
				nxt_pulse_cnt = pulse_cnt_ff + CNT_W'(1);
			end
		end else if (clk_rise) begin
			nxt_shift = {shift_ff[CH_N-2:0], serial_bit};
		end
		nxt_serial_out = nxt_shift[CH_N-1];
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			shift_ff <= '0;
			latch_ff <= '0;
			cfg_ff <= CFG_RST;
			pulse_cnt_ff <= '0;
			serial_out_ff <= 1'b0;
		end else begin
			shift_ff <= nxt_shift;
			latch_ff <= nxt_latch;
			cfg_ff <= nxt_cfg;
			pulse_cnt_ff <= nxt_pulse_cnt;
			serial_out_ff <= nxt_serial_out;
		end
	end

	// ----------------------------------------
	// Channel drive and fault detection
	// ----------------------------------------
	lsd_state_e state_ff;
	lsd_state_e nxt_state;
	logic [CH_N-1:0] sink_ff;
	logic [CH_N-1:0] nxt_sink;
	logic test_cur_ff;
	logic nxt_test_cur;
	logic [CH_N-1:0] nxt_fault;
	logic nxt_temp_flag;
	logic fault_event;

	// Forced test overrides both blanking and latched data, since it
	// must see every channel; display checking only sees lit channels
	always_comb begin
		nxt_state = state_ff;
		nxt_fault = fault_ff;
		nxt_sink = oe_n_s ? '0 : latch_ff;
		nxt_test_cur = 1'b0;
		fault_event = 1'b0;
		unique case (state_ff)
			ST_IDLE: begin
				if (force_start) begin
					nxt_state = ST_FORCE;
				end else if (!oe_n_s) begin
					for (int i = 0; i < CH_N; i++) begin
						if (sink_ff[i]) begin
							nxt_fault[i] = ~(open_s[i] | short_s[i]);
						end
					end
				end
			end
			ST_FORCE: begin
				nxt_sink = '1;
				nxt_test_cur = force_busy; // Test current follows the timer busy flag one cycle late
				if (force_done) begin
					nxt_state = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				nxt_fault = ~(open_s | short_s);
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (force_start) begin
			nxt_sink = '1;
			nxt_test_cur = 1'b1;
		end
		fault_event = (nxt_fault != fault_ff) && (nxt_fault != FAULT_RST);
		nxt_temp_flag = temp_s;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_ff <= ST_IDLE;
			sink_ff <= '0;
			test_cur_ff <= 1'b0;
			fault_ff <= FAULT_RST;
			temp_flag_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sink_ff <= nxt_sink;
			test_cur_ff <= nxt_test_cur;
			fault_ff <= nxt_fault;
			temp_flag_ff <= nxt_temp_flag;
		end
	end

	// ----------------------------------------
	// Register port and interrupt
	// ----------------------------------------
	lsd_evt_s evt;
	lsd_evt_s status_ff;
	lsd_evt_s nxt_status;
	logic [EVT_W-1:0] irq_en_ff;
	logic [EVT_W-1:0] nxt_irq_en;
	logic [EVT_W-1:0] clr_mask;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic irq_ff;
	logic nxt_irq;

	// Events show in the status bits one cycle after they happen
	always_comb begin
		evt.temp_warn = temp_s & ~temp_flag_ff;
		evt.fault_seen = fault_event;
		evt.force_done = (state_ff == ST_SAMPLE);
		evt.cfg_written = cfg_written;
	end

	// A set in the cycle of a clear wins, so no event is lost
	always_comb begin
		clr_mask = '0;
		nxt_irq_en = irq_en_ff;
		nxt_rdata = '0;
		if (reg_wr_in && reg_addr_in == REG_CLEAR) begin
			clr_mask = reg_wdata_in[EVT_W-1:0];
		end
		if (reg_wr_in && reg_addr_in == REG_ENABLE) begin
			nxt_irq_en = reg_wdata_in[EVT_W-1:0];
		end
		nxt_status = lsd_evt_s'((status_ff & ~clr_mask) | evt);
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_STATUS: nxt_rdata = {{(DATA_W-EVT_W){1'b0}}, status_ff};
				REG_ENABLE: nxt_rdata = {{(DATA_W-EVT_W){1'b0}}, irq_en_ff};
				REG_CONFIG: nxt_rdata = cfg_ff;
				REG_FAULT: nxt_rdata = fault_ff;
				REG_LATCH: nxt_rdata = latch_ff;
				default: nxt_rdata = '0;
			endcase
		end
		nxt_irq = |(nxt_status & nxt_irq_en);
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			status_ff <= '0;
			irq_en_ff <= IRQ_EN_RST;
			rdata_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			irq_en_ff <= nxt_irq_en;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Gain steps run linearly from code 0 (one eighth) to 63 (twice nominal)
	assign gain_code_out = cfg_ff[GAIN_LSB +: GAIN_W];
	assign serial_out_out = serial_out_ff;
	assign sink_channels_out = sink_ff;
	assign test_current_out = test_cur_ff;
	assign reg_rdata_out = rdata_ff;
	assign irq_out = irq_ff;
endmodule
